// file: pmc_core_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
// Core-side end: turns user requests into bus writes and requests.
// Keeps software habits: reserved bit forced to zero, external
// interrupts enabled before power-down.
module pmc_core_end
(
	input wire logic clk_i,
	input wire logic rstn_i,
	pmc_if.core bus,
	input wire logic mask_we_i,
	input wire logic [7:0] mask_wdata_i,
	input wire logic idle_req_i,
	input wire logic pdown_req_i,
	input wire logic [5:0] irq_src_i,
	input wire logic hw_rst_i,
	output logic [7:0] mask_o,
	output logic [1:0] mode_o,
	output logic cpu_run_o,
	output logic [5:0] irq_ack_o
);
	logic mask_we_q;
	logic [7:0] mask_wdata_q;
	logic idle_q;
	logic pdown_q;
	logic [5:0] src_q;
	logic rst_q;
	logic pd_ok;
	assign pd_ok = bus.mask[`PMC_IE_GLOBAL_BIT] &
		(bus.mask[`PMC_IE_EXT0_BIT] | bus.mask[`PMC_IE_EXT1_BIT]);
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mask_we_q <= 1'b0;
			mask_wdata_q <= 8'h00;
			idle_q <= 1'b0;
			pdown_q <= 1'b0;
			src_q <= 6'h00;
			rst_q <= 1'b0;
		end
		else
		begin
			mask_we_q <= mask_we_i;
			mask_wdata_q <= mask_wdata_i & ~(8'h01 << `PMC_IE_RSVD_BIT);
			idle_q <= idle_req_i;
			pdown_q <= pdown_req_i & pd_ok;
			src_q <= irq_src_i;
			rst_q <= hw_rst_i;
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mask_o <= 8'h00;
			mode_o <= 2'b00;
			cpu_run_o <= 1'b1;
			irq_ack_o <= 6'h00;
		end
		else
		begin
			mask_o <= bus.mask;
			mode_o <= bus.mode;
			cpu_run_o <= bus.cpu_run;
			irq_ack_o <= bus.irq_ack;
		end
	end
	assign bus.mask_we = mask_we_q;
	assign bus.mask_wdata = mask_wdata_q;
	assign bus.idle_req = idle_q;
	assign bus.pdown_req = pdown_q;
	assign bus.irq_src = src_q;
	assign bus.hw_rst = rst_q;
endmodule // pmc_core_end
`default_nettype wire

// file: pmc_dev_end.sv
// Behaviour
// - Global enable clear blocks every interrupt
// - Global set: each source gated by own
// - Enable one permits, zero blocks
// - Mask bit layout for timers and externals
// - Bit four gates shared serial interrupt
// - Software never writes reserved bit six
// - Idle stops CPU, peripherals keep running
// - Idle keeps RAM and registers intact
// - Idle exits on enabled interrupt or reset
// - Reset exit: two cycles, RAM blocked
// - No port write right after idle
// - Strobes high in idle, low powered down
// - Power-down stops oscillator immediately
// - Power-down retains RAM and registers
// - Power-down exits on reset or external
// - Reset from power-down reinits registers only
// - Enable external interrupt before power-down
// - Service starts 16 ms after wake pin
// - Reset held until oscillator stable; the code leaves power-down or wake on the first reset cycle
// - Six vectors, each gated by enable
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_dev_end
#(
	parameter int WAKE_CYCLES = `PMC_WAKE_CYCLES,
	parameter int IDLE_RST_CYCLES = `PMC_IDLE_RST_MCYC * `PMC_MCYC_CLKS,
	parameter bit EXT_PROG = 1'b0
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	pmc_if.dev bus,
	input wire logic [7:0] port0_data_i,
	input wire logic [7:0] port2_data_i,
	input wire logic [7:0] port2_addr_i,
	output logic addr_latch_o,
	output logic prog_fetch_strobe_o,
	output logic [7:0] port0_o,
	output logic port0_oe_o,
	output logic [7:0] port2_o,
	output logic sfr_reinit_o
);
	/****************
	 * Registers
	 ****************/
	pmc_pkg::pmc_mask_t interrupt_enable_mask_q;
	pmc_pkg::pmc_state_e state_q;
	logic idle_req_q;
	logic pdown_req_q;
	logic [5:0] ack_q;
	logic [31:0] cnt_q;
	logic ram_block_q;
	logic sfr_reinit_q;
	logic [5:0] pending;
	logic ext_pending;
	logic rst_idle;
	logic rst_pd;
	function automatic logic [5:0] pmc_gate
	(
		input logic [7:0] m,
		input logic [5:0] s
	);
		logic [5:0] en;
		en = {m[`PMC_IE_TMR2_BIT], m[`PMC_IE_SER_BIT], m[`PMC_IE_TMR1_BIT],
			m[`PMC_IE_EXT1_BIT], m[`PMC_IE_TMR0_BIT], m[`PMC_IE_EXT0_BIT]};
		pmc_gate = m[`PMC_IE_GLOBAL_BIT] ? (s & en) : 6'h00;
	endfunction
	assign pending = pmc_gate(interrupt_enable_mask_q, bus.irq_src);
	// Only the two external sources can wake a stopped oscillator.
	assign ext_pending = pending[0] | pending[2];
	assign rst_idle = bus.hw_rst & (state_q == pmc_pkg::PMC_IDLE);
	assign rst_pd = bus.hw_rst & (state_q == pmc_pkg::PMC_PDOWN ||
		state_q == pmc_pkg::PMC_WAKE);
	/****************
	 * Mask register
	 ****************/
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			interrupt_enable_mask_q <= `PMC_IE_RESET;
		else if (rst_pd || (bus.hw_rst && state_q == pmc_pkg::PMC_RUN))
			interrupt_enable_mask_q <= `PMC_IE_RESET;
		else if (bus.mask_we && state_q == pmc_pkg::PMC_RUN)
			interrupt_enable_mask_q <= bus.mask_wdata;
	end
	/****************
	 * Mode sequencer
	 ****************/
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= pmc_pkg::PMC_RUN;
			idle_req_q <= 1'b0;
			pdown_req_q <= 1'b0;
			cnt_q <= 32'h0000_0000;
			ram_block_q <= 1'b0;
			sfr_reinit_q <= 1'b0;
		end
		else
		begin
			sfr_reinit_q <= 1'b0;
			if (cnt_q != 32'h0000_0000)
				cnt_q <= cnt_q - 32'h0000_0001;
			case (state_q)
				pmc_pkg::PMC_RUN:
				begin
					ram_block_q <= ram_block_q & (cnt_q > 32'h0000_0001);
					if (bus.pdown_req)
					begin
						pdown_req_q <= 1'b1;
						state_q <= pmc_pkg::PMC_PDOWN;
					end
					else if (bus.idle_req)
					begin
						idle_req_q <= 1'b1;
						state_q <= pmc_pkg::PMC_IDLE;
					end
				end
				pmc_pkg::PMC_IDLE:
				begin
					if (rst_idle || pending != 6'h00)
					begin
						idle_req_q <= 1'b0;
						state_q <= pmc_pkg::PMC_RUN;
					end
					if (rst_idle)
					begin
						ram_block_q <= 1'b1;
						cnt_q <= 32'(IDLE_RST_CYCLES);
					end
				end
				pmc_pkg::PMC_PDOWN:
				begin
					if (rst_pd)
					begin
						pdown_req_q <= 1'b0;
						sfr_reinit_q <= 1'b1;
						state_q <= pmc_pkg::PMC_RUN;
					end
					else if (ext_pending)
					begin
						cnt_q <= 32'(WAKE_CYCLES);
						state_q <= pmc_pkg::PMC_WAKE;
					end
				end
				pmc_pkg::PMC_WAKE:
				begin
					if (rst_pd || cnt_q == 32'h0000_0001)
					begin
						pdown_req_q <= 1'b0;
						sfr_reinit_q <= rst_pd;
						state_q <= pmc_pkg::PMC_RUN;
					end
				end
				default:
					state_q <= pmc_pkg::PMC_RUN;
			endcase
		end
	end
	/****************
	 * Acknowledge and pins
	 ****************/
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ack_q <= 6'h00;
		else if (state_q == pmc_pkg::PMC_RUN ||
			(state_q == pmc_pkg::PMC_WAKE && cnt_q == 32'h0000_0001))
			ack_q <= pending;
		else
			ack_q <= 6'h00;
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			addr_latch_o <= 1'b1;
			prog_fetch_strobe_o <= 1'b1;
			port0_o <= 8'h00;
			port0_oe_o <= 1'b0;
			port2_o <= 8'h00;
			sfr_reinit_o <= 1'b0;
		end
		else
		begin
			addr_latch_o <= !(state_q == pmc_pkg::PMC_PDOWN ||
				state_q == pmc_pkg::PMC_WAKE);
			prog_fetch_strobe_o <= !(state_q == pmc_pkg::PMC_PDOWN ||
				state_q == pmc_pkg::PMC_WAKE);
			port0_o <= port0_data_i;
			port0_oe_o <= !EXT_PROG;
			port2_o <= (EXT_PROG && state_q == pmc_pkg::PMC_IDLE) ?
				port2_addr_i : port2_data_i;
			sfr_reinit_o <= sfr_reinit_q;
		end
	end
	assign bus.mask = interrupt_enable_mask_q;
	assign bus.mode = {pdown_req_q, idle_req_q};
	assign bus.cpu_run = (state_q == pmc_pkg::PMC_RUN);
	assign bus.osc_run = !(state_q == pmc_pkg::PMC_PDOWN ||
		state_q == pmc_pkg::PMC_WAKE);
	assign bus.ram_block = ram_block_q;
	assign bus.irq_ack = ack_q;
endmodule // pmc_dev_end
`default_nettype wire

// file: pmc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmc_if;
	logic mask_we;
	logic [7:0] mask_wdata;
	logic idle_req;
	logic pdown_req;
	logic [7:0] mask;
	logic [1:0] mode;
	logic cpu_run;
	logic osc_run;
	logic ram_block;
	logic [5:0] irq_ack;
	logic [5:0] irq_src;
	logic hw_rst;
	modport dev
	(
		input mask_we, mask_wdata, idle_req, pdown_req, irq_src, hw_rst,
		output mask, mode, cpu_run, osc_run, ram_block, irq_ack
	);
	modport core
	(
		output mask_we, mask_wdata, idle_req, pdown_req, irq_src, hw_rst,
		input mask, mode, cpu_run, osc_run, ram_block, irq_ack
	);
endinterface
`default_nettype wire

// file: pmc_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Link checker.
// ****
module pmc_link_sva
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] mask,
	input wire logic [1:0] mode,
	input wire logic idle_req,
	input wire logic pdown_req,
	input wire logic hw_rst,
	input wire logic cpu_run,
	input wire logic osc_run,
	input wire logic ram_block,
	input wire logic [5:0] irq_src,
	input wire logic [5:0] irq_ack
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_go_idle;
		cpu_run && mode == 2'b00 && idle_req && !pdown_req && !hw_rst;
	endsequence
	sequence s_go_down;
		cpu_run && mode == 2'b00 && pdown_req && !hw_rst;
	endsequence
	sequence s_idle_hit;
		mode == 2'b01 && mask[7] && |(mask[5:0] & irq_src);
	endsequence
	a_global_off_quiet: assert property (!mask[7] |=> irq_ack == 6'h00)
		else $error("ack with global off");
	a_ack_per_bit: assert property (cpu_run |=>
		irq_ack == $past(mask[5:0] & irq_src & {6{mask[7]}}))
		else $error("ack not gated");
	a_idle_entry: assert property (s_go_idle |=>
		mode == 2'b01 && !cpu_run) else $error("no idle");
	a_idle_clock: assert property (mode == 2'b01 |-> osc_run)
		else $error("clock off in idle");
	a_down_entry: assert property (s_go_down |=>
		mode == 2'b10 && !osc_run) else $error("no power-down");
	a_mask_frozen: assert property (!cpu_run && !hw_rst |=>
		$stable(mask)) else $error("mask moved");
	a_idle_wake: assert property (s_idle_hit |-> ##[1:2] mode == 2'b00)
		else $error("idle not left");
	// The bound suits the shortened wake-up count of 20 used on the bench.
	a_down_wake: assert property (mode == 2'b10 && mask[7] &&
		mask[0] && irq_src[0] |-> ##[1:40] mode == 2'b00)
		else $error("power-down not left");
	a_ram_guard: assert property ($rose(ram_block) |-> ram_block [*8])
		else $error("ram guard short");
	a_rsvd_clear: assert property (mask[6] == 1'b0)
		else $error("reserved bit set");
endmodule // pmc_link_sva
`default_nettype wire

// file: pmc_map.svh
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// Interrupt enable mask field positions.
`define PMC_IE_EXT0_BIT 0
`define PMC_IE_TMR0_BIT 1
`define PMC_IE_EXT1_BIT 2
`define PMC_IE_TMR1_BIT 3
`define PMC_IE_SER_BIT 4
`define PMC_IE_TMR2_BIT 5
`define PMC_IE_RSVD_BIT 6
`define PMC_IE_GLOBAL_BIT 7
`define PMC_IE_RESET 8'h00
// Wake-up delay from power-down, in ms, and the cycle count at 50 MHz.
`define PMC_CLK_HZ 50000000
`define PMC_WAKE_MS 16
`define PMC_WAKE_CYCLES ((`PMC_CLK_HZ / 1000) * `PMC_WAKE_MS)
// Machine cycles of resumed execution after a reset ends idle.
`define PMC_IDLE_RST_MCYC 2
// One machine cycle is twelve oscillator periods.
`define PMC_MCYC_CLKS 12
`endif

// file: pmc_pkg.sv
`default_nettype none
package pmc_pkg;
	typedef enum logic [1:0]
	{
		PMC_RUN = 2'b00,
		PMC_IDLE = 2'b01,
		PMC_PDOWN = 2'b10,
		PMC_WAKE = 2'b11
	} pmc_state_e;
	typedef logic [7:0] pmc_mask_t;
endpackage
`default_nettype wire

// file: power_mode_and_irq_enable_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_irq_enable_ctrl_tb;
	localparam int WAKE = 20;
	logic clk_i;
	logic rstn_i;
	logic mask_we_i;
	logic [7:0] mask_wdata_i;
	logic idle_req_i;
	logic pdown_req_i;
	logic [5:0] irq_src_i;
	logic hw_rst_i;
	logic [7:0] mask_o;
	logic [1:0] mode_o;
	logic cpu_run_o;
	logic [5:0] irq_ack_o;
	logic al_o;
	logic pf_o;
	logic sfr_reinit_o;
	logic [7:0] p0_o;
	logic p0_oe_o;
	logic [7:0] p2_o;
	logic p0_oe_x;
	logic [7:0] p2_x;
	int n_fail;
	int checked;
	pmc_if bus ();
	pmc_if bus_x ();
	assign bus_x.mask_we = bus.mask_we;
	assign bus_x.mask_wdata = bus.mask_wdata;
	assign bus_x.idle_req = bus.idle_req;
	assign bus_x.pdown_req = bus.pdown_req;
	assign bus_x.irq_src = bus.irq_src;
	assign bus_x.hw_rst = bus.hw_rst;
	pmc_core_end pmc_core_end_inst (.clk_i(clk_i), .rstn_i(rstn_i), .bus(bus),
		.mask_we_i(mask_we_i), .mask_wdata_i(mask_wdata_i),
		.idle_req_i(idle_req_i), .pdown_req_i(pdown_req_i),
		.irq_src_i(irq_src_i), .hw_rst_i(hw_rst_i), .mask_o(mask_o),
		.mode_o(mode_o), .cpu_run_o(cpu_run_o), .irq_ack_o(irq_ack_o));
	pmc_dev_end #(.WAKE_CYCLES(WAKE)) pmc_dev_end_inst (.clk_i(clk_i),
		.rstn_i(rstn_i), .bus(bus), .port0_data_i(8'h5A),
		.port2_data_i(8'hC3), .port2_addr_i(8'h3C), .addr_latch_o(al_o),
		.prog_fetch_strobe_o(pf_o), .port0_o(p0_o), .port0_oe_o(p0_oe_o),
		.port2_o(p2_o), .sfr_reinit_o(sfr_reinit_o));
	// A second device end fetches from external program memory on a copy
	// of the link, so the address drive on the high port in idle is seen.
	pmc_dev_end #(.WAKE_CYCLES(WAKE), .EXT_PROG(1'b1)) pmc_dev_end_ext_inst
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.bus(bus_x),
		.port0_data_i(8'h5A),
		.port2_data_i(8'hC3),
		.port2_addr_i(8'h3C),
		.addr_latch_o(),
		.prog_fetch_strobe_o(),
		.port0_o(),
		.port0_oe_o(p0_oe_x),
		.port2_o(p2_x),
		.sfr_reinit_o()
	);
	pmc_link_sva pmc_link_sva_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.mask(bus.mask), .mode(bus.mode), .idle_req(bus.idle_req),
		.pdown_req(bus.pdown_req), .hw_rst(bus.hw_rst), .cpu_run(bus.cpu_run),
		.osc_run(bus.osc_run), .ram_block(bus.ram_block),
		.irq_src(bus.irq_src), .irq_ack(bus.irq_ack));
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Each stage of the core end adds a cycle, so four cycles settle all.
	task automatic wr(input logic [7:0] m);
		mask_we_i = 1'b1;
		mask_wdata_i = m;
		step(1);
		mask_we_i = 1'b0;
		step(4);
	endtask
	task automatic req(input logic down);
		idle_req_i = !down;
		pdown_req_i = down;
		step(1);
		idle_req_i = 1'b0;
		pdown_req_i = 1'b0;
		step(4);
	endtask
	task automatic t_mask();
		int i;
		wr(8'hFF);
		chk(mask_o, 8'hBF);
		irq_src_i = 6'h3F;
		step(4);
		chk({2'b00, irq_ack_o}, 8'h3F);
		for (i = 0; i < 6; i++)
		begin
			wr(8'h80 | (8'h01 << i));
			chk({2'b00, irq_ack_o}, 8'h01 << i);
		end
		wr(8'h3F);
		chk({2'b00, irq_ack_o}, 8'h00);
		irq_src_i = 6'h00;
	endtask
	task automatic t_idle();
		wr(8'h84);
		req(1'b0);
		chk({6'h00, mode_o}, 8'h01);
		chk({7'h00, cpu_run_o}, 8'h00);
		chk({6'h00, al_o, pf_o}, 8'h03);
		chk(p0_o, 8'h5A);
		chk({7'h00, p0_oe_o}, 8'h01);
		chk(p2_o, 8'hC3);
		chk({7'h00, p0_oe_x}, 8'h00);
		chk(p2_x, 8'h3C);
		wr(8'hFF);
		chk(mask_o, 8'h84);
		irq_src_i = 6'h04;
		step(4);
		chk({6'h00, mode_o}, 8'h00);
		chk(p2_x, 8'hC3);
		irq_src_i = 6'h00;
		req(1'b0);
		hw_rst_i = 1'b1;
		step(1);
		hw_rst_i = 1'b0;
		step(4);
		chk({7'h00, bus.ram_block}, 8'h01);
		chk({6'h00, mode_o}, 8'h00);
		chk(mask_o, 8'h84);
		step(30);
		chk({7'h00, bus.ram_block}, 8'h00);
	endtask
	task automatic t_pdown();
		int k;
		logic [7:0] seen;
		wr(8'h85);
		req(1'b1);
		chk({6'h00, mode_o}, 8'h02);
		chk({7'h00, bus.osc_run}, 8'h00);
		chk({6'h00, al_o, pf_o}, 8'h00);
		wr(8'h00);
		chk(mask_o, 8'h85);
		irq_src_i = 6'h01;
		k = 0;
		while (mode_o !== 2'b00 && k < 100)
		begin
			step(1);
			k++;
		end
		if (k == 100)
		begin
			n_fail++;
			report_and_stop();
		end
		// Source register, wake step and output register add three cycles.
		chk(8'(k), 8'(WAKE + 3));
		step(2);
		chk({2'b00, irq_ack_o}, 8'h01);
		irq_src_i = 6'h00;
		req(1'b1);
		hw_rst_i = 1'b1;
		seen = 8'h00;
		for (k = 0; k < 8; k++)
		begin
			step(1);
			seen = seen + sfr_reinit_o;
		end
		hw_rst_i = 1'b0;
		step(6);
		chk({6'h00, mode_o}, 8'h00);
		chk(mask_o, 8'h00);
		chk(seen, 8'h01);
	endtask
	task automatic t_reset();
		wr(8'h81);
		irq_src_i = 6'h3F;
		step(4);
		chk({2'b00, irq_ack_o}, 8'h01);
		rstn_i = 1'b0;
		step(1);
		chk(mask_o, 8'h00);
		chk({6'h00, al_o, pf_o}, 8'h03);
		rstn_i = 1'b1;
		step(3);
		chk({2'b00, irq_ack_o}, 8'h00);
		irq_src_i = 6'h00;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial
	begin
		n_fail = 0;
		checked = 0;
		rstn_i = 1'b0;
		mask_we_i = 1'b0;
		mask_wdata_i = 8'h00;
		idle_req_i = 1'b0;
		pdown_req_i = 1'b0;
		irq_src_i = 6'h00;
		hw_rst_i = 1'b0;
		step(4);
		rstn_i = 1'b1;
		step(1);
		t_mask();
		t_idle();
		t_pdown();
		t_reset();
		report_and_stop();
	end
endmodule // power_mode_and_irq_enable_ctrl_tb
`default_nettype wire
